// File: core/contact_prog_pkg.sv
package contact_prog_pkg;

  // ------------------------------------------------------------
  // Array and mode code
  // ------------------------------------------------------------
  localparam int          ARRAY_BITS      = 154;
  localparam int          CODE_BITS       = 10;
  localparam logic [9:0]  CODE_ERASE      = 10'h1d4;  // 0111010100
  localparam logic [9:0]  CODE_PROGRAM    = 10'h1d2;  // 0111010010
  localparam logic [9:0]  CODE_READ       = 10'h1d6;  // 0111010110

  // ------------------------------------------------------------
  // Clock pulse numbering on the clock pad
  // ------------------------------------------------------------
  localparam logic [7:0]  EDGE_CODE_DONE  = 8'h0a;    // Pulse 10 holds the last code bit
  localparam logic [7:0]  EDGE_FIRST_SLOT = 8'h0b;    // Pulse 11 opens slot of bit 0
  localparam logic [7:0]  EDGE_ERASE_END  = 8'h0c;    // Pulse 12 ends the erase sequence
  localparam logic [7:0]  EDGE_SEQ_END    = 8'ha5;    // Pulse 165 ends program and read

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 20;
  localparam int          PAD_HALF_NS     = 1000;
  localparam logic [15:0] PAD_HALF_CYC    = 16'((PAD_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int          BIT_WRITE_US    = 100;

  // ------------------------------------------------------------
  // Modes selected by the code
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_ERASE   = 2'h0,
    MODE_PROGRAM = 2'h1,
    MODE_READ    = 2'h2
  } mode_t;

  function automatic logic [9:0] mode_code(input mode_t m);
    unique case (m)
      MODE_ERASE:   mode_code = CODE_ERASE;
      MODE_PROGRAM: mode_code = CODE_PROGRAM;
      default:      mode_code = CODE_READ;
    endcase
  endfunction : mode_code

endpackage : contact_prog_pkg

// File: core/contact_prog_if.sv
`timescale 1ns/1ns
`default_nettype none

interface contact_prog_if;

  // Clock pad, driven by the programmer
  logic clock_pad;
  // Programming pad, shared
  logic pad_prog_out;
  logic pad_prog_oe;
  logic pad_dev_out;
  logic pad_dev_oe;
  // Pad held at the high programming voltage
  logic high_program_voltage;
  // Resolved level; an undriven pad is pulled low
  logic program_data_pad;

  assign program_data_pad = pad_dev_oe  ? pad_dev_out  :
                            pad_prog_oe ? pad_prog_out : 1'b0;

  modport device (
    input  clock_pad,
    input  program_data_pad,
    input  high_program_voltage,
    output pad_dev_out,
    output pad_dev_oe
  );

  modport programmer (
    output clock_pad,
    output pad_prog_out,
    output pad_prog_oe,
    output high_program_voltage,
    input  program_data_pad
  );

endinterface : contact_prog_if

`default_nettype wire

// File: core/contact_prog_device.sv
// Notes on behaviour
// - code 0111010100 selects whole array erase
// - code 0111010010 selects bit programming
// - code 0111010110 selects serial read-back
// - erase sets all bits at pulse 11
// - high voltage, clock low: bit to zero
// - no pulse in slot keeps bit one
// - slots ascending bit 0..153, ends pulse 165
// - read: programmer releases, device drives when high
// - 154 free-format reprogrammable bits
// - code sampled on clock pad rising edges
// - mode starts right after last code bit
// - exit: clock high then high voltage
// - undriven pads read low
`timescale 1ns/1ns
`default_nettype none

module contact_prog_device (
  // System
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Pads
  contact_prog_if.device              pads,
  // User side
  output logic [contact_prog_pkg::ARRAY_BITS-1:0] array_bits,
  output logic [1:0]                  active_mode,
  output logic                        mode_active
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_LOAD  = 3'h0,
    ST_ERASE = 3'h1,
    ST_PROG  = 3'h3,
    ST_READ  = 3'h2,
    ST_HOLD  = 3'h6
  } dev_state_t;

  dev_state_t state_q;
  logic [contact_prog_pkg::ARRAY_BITS-1:0] mem_q;
  logic [9:0] code_q;
  logic [7:0] edge_cnt_q;
  logic [2:0] clk_sync_q;
  logic [1:0] dat_sync_q;
  logic [2:0] hv_sync_q;
  logic       clk_rise;
  logic       clk_high;
  logic       hv_rise;
  logic       exit_req;
  logic       code_last;
  logic [7:0] slot;
  logic       slot_ok;
  logic [9:0] code_next;
  logic       erase_now;
  logic       prog_now;
  logic       drive_now;
  logic       pad_out_q;
  logic       pad_oe_q;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // True when the rise being taken now is pulse number p
  function automatic logic is_pulse(input logic [7:0] cnt, input logic [7:0] p);
    is_pulse = ((cnt + 8'h01) == p);
  endfunction : is_pulse

  // True for pulse counts that own an array bit slot
  function automatic logic owns_slot(input logic [7:0] cnt);
    owns_slot = (cnt >= contact_prog_pkg::EDGE_FIRST_SLOT) &&
                (cnt < contact_prog_pkg::EDGE_SEQ_END);
  endfunction : owns_slot

  // Maps a complete mode code to the state that runs it
  function automatic dev_state_t decode_code(input logic [9:0] code);
    unique case (code)
      contact_prog_pkg::CODE_ERASE:   decode_code = ST_ERASE;
      contact_prog_pkg::CODE_PROGRAM: decode_code = ST_PROG;
      contact_prog_pkg::CODE_READ:    decode_code = ST_READ;
      default:                        decode_code = ST_HOLD;
    endcase
  endfunction : decode_code

  // ------------------------------------------------------------
  // Pad synchronisers
  // ------------------------------------------------------------
  // The pads belong to the programmer's timing, so nothing reads stage 0
  always_ff @(posedge clk) begin
    if (rst) begin
      clk_sync_q <= 3'h0;
      dat_sync_q <= 2'h0;
      hv_sync_q  <= 3'h0;
    end else begin
      clk_sync_q <= {clk_sync_q[1:0], pads.clock_pad};
      dat_sync_q <= {dat_sync_q[0], pads.program_data_pad};
      hv_sync_q  <= {hv_sync_q[1:0], pads.high_program_voltage};
    end
  end

  assign clk_rise  = clk_sync_q[1] & ~clk_sync_q[2];
  assign clk_high  = clk_sync_q[1];
  assign hv_rise   = hv_sync_q[1] & ~hv_sync_q[2];
  // A voltage step while the clock is high ends any mode
  assign exit_req  = hv_rise & clk_high;
  assign code_last = is_pulse(edge_cnt_q, contact_prog_pkg::EDGE_CODE_DONE);
  assign slot      = edge_cnt_q - contact_prog_pkg::EDGE_FIRST_SLOT;
  assign slot_ok   = owns_slot(edge_cnt_q);
  assign code_next = {code_q[8:0], dat_sync_q[1]};

  // ------------------------------------------------------------
  // Pulse counter
  // ------------------------------------------------------------
  // Saturates so that extra pulses after the end never wrap into a slot
  always_ff @(posedge clk) begin
    if (rst) begin
      edge_cnt_q <= 8'h00;
    end else if (exit_req) begin
      edge_cnt_q <= 8'h00;
    end else if (clk_rise && edge_cnt_q != 8'hff) begin
      edge_cnt_q <= edge_cnt_q + 8'h01;
    end
  end

  // ------------------------------------------------------------
  // Mode code shift register
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      code_q <= 10'h000;
    end else if (exit_req) begin
      code_q <= 10'h000;
    end else if (clk_rise && state_q == ST_LOAD) begin
      code_q <= code_next;
    end
  end

  // ------------------------------------------------------------
  // Mode state
  // ------------------------------------------------------------
  // Exit works from any state, so a stuck or unknown sequence can recover
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= ST_LOAD;
    end else if (exit_req) begin
      state_q <= ST_LOAD;
    end else if (clk_rise && state_q == ST_LOAD && code_last) begin
      state_q <= decode_code(code_next);
    end
  end

  // ------------------------------------------------------------
  // Array; kept across reset since it stands for nonvolatile cells
  // ------------------------------------------------------------
  // Erase lands on pulse 11; a bit is written only with the clock low
  assign erase_now = (state_q == ST_ERASE) && clk_rise &&
                     is_pulse(edge_cnt_q, contact_prog_pkg::EDGE_FIRST_SLOT);
  assign prog_now  = (state_q == ST_PROG) && hv_rise && !clk_high && slot_ok;

  always_ff @(posedge clk) begin
    if (erase_now) begin
      mem_q <= '1;
    end else if (prog_now) begin
      mem_q[slot] <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Read-back drive
  // ------------------------------------------------------------
  // The pulse count steps one cycle after the synced rise, so that cycle
  // is skipped: driving then would show the previous slot and, after the
  // last slot, clash with the programmer taking the pad back
  assign drive_now = (state_q == ST_READ) && clk_high && !clk_rise && slot_ok;

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
    end else begin
      pad_oe_q  <= drive_now;
      pad_out_q <= slot_ok ? mem_q[slot] : 1'b0;
    end
  end

  assign pads.pad_dev_out = pad_out_q;
  assign pads.pad_dev_oe  = pad_oe_q;
  assign array_bits       = mem_q;
  assign mode_active      = (state_q != ST_LOAD) && (state_q != ST_HOLD);
  assign active_mode      = (state_q == ST_PROG) ? 2'h1 :
                            (state_q == ST_READ) ? 2'h2 : 2'h0;

endmodule : contact_prog_device

`default_nettype wire

// File: core/contact_prog_programmer.sv
`timescale 1ns/1ns
`default_nettype none

module contact_prog_programmer #(
  parameter int BIT_WRITE_US = contact_prog_pkg::BIT_WRITE_US
) (
  // System
  input  wire logic                   clk,
  input  wire logic                   rst,
  // Pads
  contact_prog_if.programmer          pads,
  // User side
  input  wire logic                   start,
  input  wire logic [1:0]             mode,
  input  wire logic [contact_prog_pkg::ARRAY_BITS-1:0] write_bits,
  output logic [contact_prog_pkg::ARRAY_BITS-1:0] read_bits,
  output logic                        busy,
  output logic                        done
);

  localparam logic [15:0] WRITE_CYC =
    16'((BIT_WRITE_US * 1000 + contact_prog_pkg::CLK_PERIOD_NS - 1) /
        contact_prog_pkg::CLK_PERIOD_NS);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    PS_IDLE  = 3'h0,
    PS_LOW   = 3'h1,
    PS_HIGH  = 3'h3,
    PS_PULSE = 3'h2,
    PS_EXIT  = 3'h6
  } prog_state_t;

  prog_state_t state_q;
  contact_prog_pkg::mode_t mode_q;
  logic [contact_prog_pkg::ARRAY_BITS-1:0] wr_q;
  logic [contact_prog_pkg::ARRAY_BITS-1:0] rd_q;
  logic [9:0]  code_q;
  logic [7:0]  cnt_q;
  logic [15:0] tmr_q;
  logic        pclk_q;
  logic        hv_q;
  logic        dout_q;
  logic        doe_q;
  logic        done_q;
  logic [1:0]  pad_sync_q;
  logic [7:0]  slot;
  logic        in_slot;
  logic [7:0]  last_edge;

  assign slot      = cnt_q - contact_prog_pkg::EDGE_FIRST_SLOT;
  assign in_slot   = (cnt_q >= contact_prog_pkg::EDGE_FIRST_SLOT) &&
                     (cnt_q < contact_prog_pkg::EDGE_SEQ_END);
  assign last_edge = (mode_q == contact_prog_pkg::MODE_ERASE) ?
                     contact_prog_pkg::EDGE_ERASE_END : contact_prog_pkg::EDGE_SEQ_END;

  always_ff @(posedge clk) begin
    if (rst)
      pad_sync_q <= 2'h0;
    else
      pad_sync_q <= {pad_sync_q[0], pads.program_data_pad};
  end

  // ------------------------------------------------------------
  // Sequencer; one pad clock pulse per low and high half period
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= PS_IDLE;
      mode_q  <= contact_prog_pkg::MODE_ERASE;
      wr_q    <= '0;
      rd_q    <= '0;
      code_q  <= 10'h000;
      cnt_q   <= 8'h00;
      tmr_q   <= 16'h0000;
      pclk_q  <= 1'b0;
      hv_q    <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (tmr_q != 16'h0000)
        tmr_q <= tmr_q - 16'h0001;
      unique case (state_q)
        PS_IDLE: begin
          if (start) begin
            mode_q  <= contact_prog_pkg::mode_t'(mode);
            code_q  <= contact_prog_pkg::mode_code(contact_prog_pkg::mode_t'(mode));
            wr_q    <= write_bits;
            cnt_q   <= 8'h00;
            tmr_q   <= contact_prog_pkg::PAD_HALF_CYC;
            state_q <= PS_LOW;
          end
        end
        PS_LOW: begin
          if (tmr_q == 16'h0000) begin
            if (cnt_q == last_edge) begin
              pclk_q  <= 1'b1;
              tmr_q   <= contact_prog_pkg::PAD_HALF_CYC;
              state_q <= PS_EXIT;
            end else begin
              pclk_q  <= 1'b1;
              cnt_q   <= cnt_q + 8'h01;
              tmr_q   <= contact_prog_pkg::PAD_HALF_CYC;
              state_q <= PS_HIGH;
            end
          end
        end
        PS_HIGH: begin
          if (tmr_q == 16'h0000) begin
            pclk_q <= 1'b0;
            if (mode_q == contact_prog_pkg::MODE_READ && in_slot)
              rd_q[slot] <= pad_sync_q[1];
            if (mode_q == contact_prog_pkg::MODE_PROGRAM && in_slot && !wr_q[slot]) begin
              hv_q    <= 1'b1;
              tmr_q   <= WRITE_CYC;
              state_q <= PS_PULSE;
            end else begin
              tmr_q   <= contact_prog_pkg::PAD_HALF_CYC;
              state_q <= PS_LOW;
            end
          end
        end
        PS_PULSE: begin
          if (tmr_q == 16'h0000) begin
            hv_q    <= 1'b0;
            tmr_q   <= contact_prog_pkg::PAD_HALF_CYC;
            state_q <= PS_LOW;
          end
        end
        PS_EXIT: begin
          // Clock is already high, so the voltage step ends the mode
          if (tmr_q == 16'h0000) begin
            if (!hv_q) begin
              hv_q  <= 1'b1;
              tmr_q <= contact_prog_pkg::PAD_HALF_CYC;
            end else begin
              hv_q    <= 1'b0;
              pclk_q  <= 1'b0;
              done_q  <= 1'b1;
              state_q <= PS_IDLE;
            end
          end
        end
        default: state_q <= PS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pad drive: code bits leftmost first, released during read slots
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      dout_q <= 1'b0;
      doe_q  <= 1'b0;
    end else begin
      doe_q  <= (state_q != PS_IDLE) &&
                !(mode_q == contact_prog_pkg::MODE_READ && in_slot);
      dout_q <= (state_q == PS_LOW && cnt_q < contact_prog_pkg::EDGE_CODE_DONE) ?
                code_q[4'(9 - cnt_q)] : hv_q;
    end
  end

  assign pads.clock_pad            = pclk_q;
  assign pads.high_program_voltage = hv_q;
  // Pad level must rise with the voltage step, not one cycle after it
  assign pads.pad_prog_out         = dout_q | hv_q;
  assign pads.pad_prog_oe          = doe_q;
  assign read_bits                 = rd_q;
  assign busy                      = (state_q != PS_IDLE);
  assign done                      = done_q;

endmodule : contact_prog_programmer

`default_nettype wire

// File: verification/contact_prog_monitor.sv
`timescale 1ns/1ns
`default_nettype none

module contact_prog_monitor (
  // System
  input wire logic clk,
  input wire logic rst,
  // Pads
  input wire logic clock_pad,
  input wire logic pad_prog_out,
  input wire logic pad_prog_oe,
  input wire logic pad_dev_out,
  input wire logic pad_dev_oe,
  input wire logic high_program_voltage,
  input wire logic program_data_pad
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  chk_one_driver: assert property (!(pad_dev_oe && pad_prog_oe))
    else $error("Both ends drive the data pad");
  chk_pull_low: assert property (!pad_dev_oe && !pad_prog_oe |-> !program_data_pad)
    else $error("Undriven data pad not low");
  chk_dev_value: assert property (pad_dev_oe |-> program_data_pad == pad_dev_out)
    else $error("Data pad does not show the device bit");
  chk_drive_in_high: assert property ($rose(pad_dev_oe) |-> clock_pad)
    else $error("Device drive starts with clock low");
  chk_drive_release: assert property (pad_dev_oe && !clock_pad |-> ##[0:6] !pad_dev_oe)
    else $error("Device keeps driving after clock fell");
  // Pads pass a synchroniser, so each half must outlast it
  chk_high_hold: assert property ($rose(clock_pad) |=> clock_pad [*7])
    else $error("Clock pad high phase too short");
  chk_low_hold: assert property ($fell(clock_pad) |=> !clock_pad [*7])
    else $error("Clock pad low phase too short");
  chk_hv_drive: assert property (high_program_voltage |-> pad_prog_oe && pad_prog_out)
    else $error("High voltage without programmer drive");
  chk_hv_hold: assert property ($rose(high_program_voltage) |=> high_program_voltage [*8])
    else $error("High voltage pulse too short");
  chk_hv_clk_still: assert property (
    high_program_voltage && $past(high_program_voltage) |-> $stable(clock_pad))
    else $error("Clock pad moved during high voltage");

endmodule : contact_prog_monitor

`default_nettype wire

// File: verification/tb_contact_programming_port.sv
`timescale 1ns/1ns
`default_nettype none

module tb_contact_programming_port;

  // ------------------------------------------------------------
  // Harness
  // ------------------------------------------------------------
  localparam int           N     = contact_prog_pkg::ARRAY_BITS;
  // Zeros at both ends catch a slot count that is off by one
  localparam logic [N-1:0] PAT_B = {1'h0, {152{1'h1}}, 1'h0};
  localparam logic [N-1:0] PAT_A = {77{2'h1}};

  logic         clk        = 1'h0;
  logic         rst        = 1'h1;
  logic         start      = 1'h0;
  logic [1:0]   mode       = 2'h0;
  logic [N-1:0] write_bits = {N{1'h0}};
  logic [N-1:0] read_bits;
  logic [N-1:0] array_bits;
  logic [1:0]   active_mode;
  logic         mode_active;
  logic         busy;
  logic         done;
  logic         clk_d      = 1'h0;
  logic [9:0]   code       = 10'h000;
  int           cnt        = 0;
  int           n_mismatch = 0;
  int           num_checks = 0;

  contact_prog_if pads ();

  contact_prog_device contact_prog_device_inst (
    .clk(clk), .rst(rst), .pads(pads.device), .array_bits(array_bits),
    .active_mode(active_mode), .mode_active(mode_active));

  // Short write pulse keeps the run small
  contact_prog_programmer #(.BIT_WRITE_US(2)) contact_prog_programmer_inst (
    .clk(clk), .rst(rst), .pads(pads.programmer), .start(start), .mode(mode),
    .write_bits(write_bits), .read_bits(read_bits), .busy(busy), .done(done));

  contact_prog_monitor contact_prog_monitor_inst (
    .clk(clk), .rst(rst), .clock_pad(pads.clock_pad), .pad_prog_out(pads.pad_prog_out),
    .pad_prog_oe(pads.pad_prog_oe), .pad_dev_out(pads.pad_dev_out),
    .pad_dev_oe(pads.pad_dev_oe), .high_program_voltage(pads.high_program_voltage),
    .program_data_pad(pads.program_data_pad));

  initial forever #10 clk = ~clk;

  // Captures the first ten pad bits seen on clock pad rises
  always @(posedge clk) begin
    clk_d <= pads.clock_pad;
    if (start) begin
      cnt <= 0;
    end else if (pads.clock_pad && !clk_d) begin
      cnt <= cnt + 1;
      if (cnt < 10) begin
        code <= {code[8:0], pads.program_data_pad};
      end
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input logic [N-1:0] got, input logic [N-1:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic run(input logic [1:0] m, input logic [N-1:0] w);
    logic [9:0] exp_code;
    int         i;
    exp_code = (m == 2'h0) ? contact_prog_pkg::CODE_ERASE :
               (m == 2'h1) ? contact_prog_pkg::CODE_PROGRAM : contact_prog_pkg::CODE_READ;
    @(negedge clk);
    mode = m;
    write_bits = w;
    start = 1'h1;
    @(negedge clk);
    start = 1'h0;
    for (i = 0; i < 30000 && done !== 1'h1; i++) begin
      @(negedge clk);
      // After the code is in, before the exit of the shortest sequence
      if (i == 1100) begin
        check(N'({busy, mode_active, active_mode}), N'({2'h3, m}));
      end
    end
    if (done !== 1'h1) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, done, 1'h1);
      conclude();
    end else begin
      check(N'(code), N'(exp_code));
      check(N'({busy, mode_active}), N'(2'h0));
    end
  endtask : run

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    repeat (16) @(posedge clk);
    @(negedge clk);
    rst = 1'h0;
    run(contact_prog_pkg::MODE_ERASE, {N{1'h0}});
    check(array_bits, {N{1'h1}});
    run(contact_prog_pkg::MODE_PROGRAM, PAT_B);
    check(array_bits, PAT_B);
    run(contact_prog_pkg::MODE_READ, {N{1'h0}});
    check(read_bits, PAT_B);
    // Second pass proves a mode can be entered again after exit
    run(contact_prog_pkg::MODE_ERASE, {N{1'h0}});
    check(array_bits, {N{1'h1}});
    run(contact_prog_pkg::MODE_PROGRAM, PAT_A);
    check(array_bits, PAT_A);
    run(contact_prog_pkg::MODE_READ, {N{1'h0}});
    check(read_bits, PAT_A);
    conclude();
  end

endmodule : tb_contact_programming_port

`default_nettype wire
